/* File: core/deser_link_audio_ctrl_map.svh */
/*
  offsets, field positions, write masks and reset values of the link and
  audio control register slice.
  assumes: included by bare name from the register bank.
*/
`ifndef DESER_LINK_AUDIO_CTRL_MAP_SVH
`define DESER_LINK_AUDIO_CTRL_MAP_SVH

// ============================================================
// offsets
`define AUDIO_OUTPUT_CONTROL_ADDR    8'h2b
`define PIXEL_CLOCK_TEST_SELECT_ADDR 8'h2e
`define DUAL_RECEIVE_CONTROL_ADDR    8'h34
`define EQUALIZER_CONTROL_ONE_ADDR   8'h35

// ============================================================
// reset values
`define AUDIO_OUTPUT_CONTROL_RST     8'h00
`define PIXEL_CLOCK_TEST_SELECT_RST  8'h00
`define DUAL_RECEIVE_CONTROL_RST     8'h01
`define EQUALIZER_CONTROL_ONE_RST    8'h00

// ============================================================
// writable bits; everything else reads back as zero, except the audio status flags in bits 3 and 2
`define AUDIO_OUTPUT_CONTROL_WMASK    8'h03
`define PIXEL_CLOCK_TEST_SELECT_WMASK 8'h80
`define DUAL_RECEIVE_CONTROL_WMASK    8'h7b
`define EQUALIZER_CONTROL_ONE_WMASK   8'h70

// ============================================================
// field positions
`define AUDIO_OVERRUN_BIT        3
`define AUDIO_UNDERRUN_BIT       2
`define AUDIO_ERROR_RESET_BIT    1
`define AUDIO_EDGE_SELECT_BIT    0
`define SELF_TEST_CLOCK_BIT      7
`define LOCK_MODE_BIT            6
`define RAW_BACKCHANNEL_BIT      5
`define LINK_MODE_HI             4
`define LINK_MODE_LO             3
`define SECOND_PORT_SELECT_BIT   1
`define FIRST_PORT_SELECT_BIT    0
`define EQ_RESTART_BIT           6
`define EQ_FLOOR_OVERRIDE_BIT    5
`define EQ_FLOOR_APPLY_BIT       4

`endif

/* File: core/deser_link_audio_ctrl_pkg.sv */
/*
  types shared by the link and audio control register slice.
  assumes: the map header supplies every number except the link mode encodings.
*/
package deser_link_audio_ctrl_pkg;

  // ============================================================
  // receiver input mode encodings
  typedef enum logic [1:0] {
    LINK_AUTO          = 2'h0,
    LINK_FORCED_DUAL   = 2'h1,
    LINK_FORCED_FIRST  = 2'h2,
    LINK_FORCED_SECOND = 2'h3
  } link_mode_t;

  typedef logic [7:0] reg_byte_t;

endpackage : deser_link_audio_ctrl_pkg

/* File: core/deser_link_audio_ctrl_regs.sv */
/*
  link, audio and equalizer control registers of the deserializer, with
  the per-port copy steering of the equalizer register.
  assumes: the local serial-bus slave on clk hands single byte accesses
  over reg_wr / reg_rd with an 8-bit address; status events and link
  state come from logic on clk; the general pin is asynchronous.
*/
// Behaviour
// - audio fifo overrun shows as read-only flag, audio control bit 3
// - audio fifo underrun shows as read-only flag, audio control bit 2
// - writing one to error reset clears overrun and underrun flags
// - edge select one strobes data on rising edge, zero on falling
// - pixel clock test bit 7 takes pixel clock from self-test input
// - lock mode zero: lock and video only while video-off flag is zero
// - lock mode one: lock whenever a serializer link exists
// - input mode: 00 auto, 01 dual, 10 primary only, 11 secondary only
// - second port select makes writes hit port-one copy and shared
// - first port select resets to one, steers writes to port 0
// - both selects set: reads return port-one copies
// - restart bit written high then low restarts equalizer on both ports
// - floor apply works only while floor override is set
// - enabled floor applies the minimum setting from the second register
// - video-off flag means no video, control channel still enabled
`timescale 1ns/1ns

`include "deser_link_audio_ctrl_map.svh"

module deser_link_audio_ctrl_regs (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // register access from the serial-bus slave
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // audio fifo events and controls
  input  wire logic       audio_overrun_event,
  input  wire logic       audio_underrun_event,
  output logic            audio_strobe_rising,
  // pixel clock source
  output logic            pixel_clock_from_self_test,
  // link state and lock
  input  wire logic       link_present,
  input  wire logic       video_off,
  input  wire logic       detected_dual_link,
  output logic            receive_lock,
  output logic            video_generate,
  output logic            control_channel_enable,
  output logic            dual_link_active,
  output logic            primary_input_enable,
  output logic            secondary_input_enable,
  // secondary back channel
  input  wire logic       local_general_pin_zero,
  input  wire logic       filtered_backchannel,
  output logic            secondary_backchannel,
  // equalizer
  input  wire logic [7:0] equalizer_minimum_setting,
  output logic            equalizer_adaptation_restart,
  output logic [1:0]      equalizer_floor_active,
  output logic [7:0]      equalizer_floor_port0,
  output logic [7:0]      equalizer_floor_port1
);

  // ============================================================
  // decode helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  // ============================================================
  // register state
  logic [7:0] audio_ctrl;
  logic [7:0] pclk_test;
  logic [7:0] dual_rx;
  logic [7:0] eq_one [2];
  logic       overrun_flag;
  logic       underrun_flag;
  logic       restart_seen;
  logic [7:0] next_audio_ctrl;
  logic [7:0] next_pclk_test;
  logic [7:0] next_dual_rx;
  logic [7:0] next_eq_one [2];
  logic       next_overrun_flag;
  logic       next_underrun_flag;
  logic       next_restart_seen;
  logic [7:0] next_rdata;
  logic       error_clear;
  logic       sel_first;
  logic       sel_second;
  logic       read_port;

  assign sel_first  = dual_rx[`FIRST_PORT_SELECT_BIT];
  assign sel_second = dual_rx[`SECOND_PORT_SELECT_BIT];
  // second select wins for reads; port-zero reads need it cleared first
  assign read_port  = sel_second;
  assign error_clear = reg_wr && hit(reg_addr, `AUDIO_OUTPUT_CONTROL_ADDR)
                       && reg_wdata[`AUDIO_ERROR_RESET_BIT];

  always_comb begin
    next_audio_ctrl = audio_ctrl;
    next_pclk_test  = pclk_test;
    next_dual_rx    = dual_rx;
    next_eq_one     = eq_one;
    next_rdata      = reg_rdata;
    // an event in the clearing cycle still lands
    next_overrun_flag  = audio_overrun_event
                         | (overrun_flag & ~error_clear);
    next_underrun_flag = audio_underrun_event
                         | (underrun_flag & ~error_clear);
    next_restart_seen  = eq_one[0][`EQ_RESTART_BIT]
                         | eq_one[1][`EQ_RESTART_BIT];
    if (reg_wr) begin
      if (hit(reg_addr, `AUDIO_OUTPUT_CONTROL_ADDR)) begin
        next_audio_ctrl = merge(audio_ctrl, reg_wdata,
                                `AUDIO_OUTPUT_CONTROL_WMASK);
      end
      if (hit(reg_addr, `PIXEL_CLOCK_TEST_SELECT_ADDR)) begin
        next_pclk_test = merge(pclk_test, reg_wdata,
                               `PIXEL_CLOCK_TEST_SELECT_WMASK);
      end
      if (hit(reg_addr, `DUAL_RECEIVE_CONTROL_ADDR)) begin
        next_dual_rx = merge(dual_rx, reg_wdata,
                             `DUAL_RECEIVE_CONTROL_WMASK);
      end
      if (hit(reg_addr, `EQUALIZER_CONTROL_ONE_ADDR)) begin
        if (sel_first) begin
          next_eq_one[0] = merge(eq_one[0], reg_wdata,
                                 `EQUALIZER_CONTROL_ONE_WMASK);
        end
        if (sel_second) begin
          next_eq_one[1] = merge(eq_one[1], reg_wdata,
                                 `EQUALIZER_CONTROL_ONE_WMASK);
        end
      end
    end
    if (reg_rd) begin
      case (reg_addr)
        `AUDIO_OUTPUT_CONTROL_ADDR: begin
          next_rdata = audio_ctrl;
          next_rdata[`AUDIO_OVERRUN_BIT]  = overrun_flag;
          next_rdata[`AUDIO_UNDERRUN_BIT] = underrun_flag;
        end
        `PIXEL_CLOCK_TEST_SELECT_ADDR: begin
          next_rdata = pclk_test;
        end
        `DUAL_RECEIVE_CONTROL_ADDR: begin
          next_rdata = dual_rx;
        end
        `EQUALIZER_CONTROL_ONE_ADDR: begin
          next_rdata = eq_one[read_port];
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      audio_ctrl    <= `AUDIO_OUTPUT_CONTROL_RST;
      pclk_test     <= `PIXEL_CLOCK_TEST_SELECT_RST;
      dual_rx       <= `DUAL_RECEIVE_CONTROL_RST;
      eq_one        <= '{2{`EQUALIZER_CONTROL_ONE_RST}};
      overrun_flag  <= 1'b0;
      underrun_flag <= 1'b0;
      restart_seen  <= 1'b0;
      reg_rdata     <= 8'h00;
    end else begin
      audio_ctrl    <= next_audio_ctrl;
      pclk_test     <= next_pclk_test;
      dual_rx       <= next_dual_rx;
      eq_one        <= next_eq_one;
      overrun_flag  <= next_overrun_flag;
      underrun_flag <= next_underrun_flag;
      restart_seen  <= next_restart_seen;
      reg_rdata     <= next_rdata;
    end
  end

  // ============================================================
  // pin synchroniser for the raw back channel
  logic pin_meta;
  logic pin_sync;
  logic next_backchannel;

  always_comb begin
    // raw mode skips filtering, so pin glitches reach the far end
    next_backchannel = dual_rx[`RAW_BACKCHANNEL_BIT] ? pin_sync
                                                     : filtered_backchannel;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta              <= 1'b0;
      pin_sync              <= 1'b0;
      secondary_backchannel <= 1'b0;
    end else begin
      pin_meta              <= local_general_pin_zero;
      pin_sync              <= pin_meta;
      secondary_backchannel <= next_backchannel;
    end
  end

  // ============================================================
  // control outputs
  deser_link_audio_ctrl_pkg::link_mode_t link_mode;
  logic       next_lock;
  logic       next_video;
  logic       next_ctrl_ch;
  logic       next_dual;
  logic       next_primary;
  logic       next_secondary;
  logic [1:0] floor_on;

  assign link_mode = deser_link_audio_ctrl_pkg::link_mode_t'(
                       dual_rx[`LINK_MODE_HI:`LINK_MODE_LO]);
  assign floor_on[0] = eq_one[0][`EQ_FLOOR_OVERRIDE_BIT]
                       & eq_one[0][`EQ_FLOOR_APPLY_BIT];
  assign floor_on[1] = eq_one[1][`EQ_FLOOR_OVERRIDE_BIT]
                       & eq_one[1][`EQ_FLOOR_APPLY_BIT];

  always_comb begin
    next_video   = link_present & ~video_off;
    next_ctrl_ch = link_present;
    next_lock    = dual_rx[`LOCK_MODE_BIT] ? link_present
                                           : next_video;
    case (link_mode)
      deser_link_audio_ctrl_pkg::LINK_AUTO: begin
        next_dual      = detected_dual_link;
        next_primary   = 1'b1;
        next_secondary = detected_dual_link;
      end
      deser_link_audio_ctrl_pkg::LINK_FORCED_DUAL: begin
        next_dual      = 1'b1;
        next_primary   = 1'b1;
        next_secondary = 1'b1;
      end
      deser_link_audio_ctrl_pkg::LINK_FORCED_FIRST: begin
        next_dual      = 1'b0;
        next_primary   = 1'b1;
        next_secondary = 1'b0;
      end
      default: begin
        next_dual      = 1'b0;
        next_primary   = 1'b0;
        next_secondary = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      receive_lock           <= 1'b0;
      video_generate         <= 1'b0;
      control_channel_enable <= 1'b0;
      dual_link_active       <= 1'b0;
      primary_input_enable   <= 1'b1;
      secondary_input_enable <= 1'b0;
    end else begin
      receive_lock           <= next_lock;
      video_generate         <= next_video;
      control_channel_enable <= next_ctrl_ch;
      dual_link_active       <= next_dual;
      primary_input_enable   <= next_primary;
      secondary_input_enable <= next_secondary;
    end
  end

  // register-held fields go straight out
  assign audio_strobe_rising = audio_ctrl[`AUDIO_EDGE_SELECT_BIT];
  assign pixel_clock_from_self_test = pclk_test[`SELF_TEST_CLOCK_BIT];
  // one pulse on the high-to-low write, shared by both ports
  assign equalizer_adaptation_restart = restart_seen
    & ~(eq_one[0][`EQ_RESTART_BIT] | eq_one[1][`EQ_RESTART_BIT]);
  assign equalizer_floor_active = floor_on;
  assign equalizer_floor_port0 = floor_on[0] ? equalizer_minimum_setting
                                             : 8'h00;
  assign equalizer_floor_port1 = floor_on[1] ? equalizer_minimum_setting
                                             : 8'h00;

  // ============================================================
  // checks
  a_overrun_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    audio_overrun_event |=> overrun_flag)
    else $error("overrun event not recorded");
  a_underrun_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    audio_underrun_event |=> underrun_flag)
    else $error("underrun event not recorded");
  a_error_clear: assert property (@(posedge clk) disable iff (sys_rst)
    error_clear && !audio_overrun_event && !audio_underrun_event
    |=> !overrun_flag && !underrun_flag)
    else $error("error reset did not clear flags");
  a_lock_follows: assert property (@(posedge clk) disable iff (sys_rst)
    dual_rx[`LOCK_MODE_BIT] && link_present
    |=> receive_lock)
    else $error("lock missing in link lock mode");
  a_lock_video: assert property (@(posedge clk) disable iff (sys_rst)
    !dual_rx[`LOCK_MODE_BIT] && video_off |=> !receive_lock)
    else $error("lock asserted without active video");
  a_raw_pass: assert property (@(posedge clk) disable iff (sys_rst)
    dual_rx[`RAW_BACKCHANNEL_BIT] |=>
    secondary_backchannel == $past(pin_sync))
    else $error("raw back channel not passing pin");
  a_mode_forced: assert property (@(posedge clk) disable iff (sys_rst)
    dual_rx[`LINK_MODE_HI:`LINK_MODE_LO] == 2'h3
    |=> !primary_input_enable && secondary_input_enable)
    else $error("secondary-only mode wrong");
  a_port_one_write: assert property (@(posedge clk) disable iff (sys_rst)
    reg_wr && hit(reg_addr, `EQUALIZER_CONTROL_ONE_ADDR) && !sel_second
    |=> eq_one[1] == $past(eq_one[1]))
    else $error("port-one copy written while unselected");
  a_read_steer: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && hit(reg_addr, `EQUALIZER_CONTROL_ONE_ADDR) && sel_second
    |=> reg_rdata == $past(eq_one[1]))
    else $error("read did not return port-one copy");
  a_restart_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    equalizer_adaptation_restart |=> !equalizer_adaptation_restart)
    else $error("restart longer than one cycle");
  a_floor_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !eq_one[0][`EQ_FLOOR_OVERRIDE_BIT]
    |-> !equalizer_floor_active[0] && equalizer_floor_port0 == 8'h00)
    else $error("floor applied without override");
  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
    dual_rx[7] == 1'b0 && dual_rx[2] == 1'b0
    && audio_ctrl[7:2] == 6'h00)
    else $error("reserved or status bit stored");

endmodule : deser_link_audio_ctrl_regs

/* File: tb/host_bus_model.sv */
/*
  host side of the register bus: single byte write and read cycles.
  assumes: strobes are sampled on the rising edge of clk.
*/
`timescale 1ns/1ns

module host_bus_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // ============================================================
  // one request, held across exactly one sampling edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    #2;
    reg_wr    = w;
    reg_rd    = !w;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #2;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    // released lines show the inverse so stale values never look valid
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : xfer
endmodule : host_bus_model

/* File: tb/tb_deser_link_audio_ctrl_regs.sv */
/*
  self-checking bench for the link and audio control register slice.
  assumes: host_bus_model drives the register bus; read data is compared
  by a monitor against a queue of expected bytes.
*/
`timescale 1ns/1ns

module tb_deser_link_audio_ctrl_regs;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       reg_wr, reg_rd, rd_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, min_set, fl0, fl1;
  logic       ovr = 1'b0, udr = 1'b0, link = 1'b0, voff = 1'b0;
  logic       det = 1'b0, pin = 1'b0, filt = 1'b0;
  logic       strobe, pixclk, lock, vgen, ctrl, dual, pri, sec, bch, rst_eq;
  logic [1:0] fl_act;
  logic [7:0] exp_q[$];
  int         fails = 0;
  int         checks = 0;

  always #10 clk = ~clk;

  host_bus_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  deser_link_audio_ctrl_regs dut (.clk(clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .audio_overrun_event(ovr), .audio_underrun_event(udr),
    .audio_strobe_rising(strobe), .pixel_clock_from_self_test(pixclk),
    .link_present(link), .video_off(voff), .detected_dual_link(det),
    .receive_lock(lock), .video_generate(vgen),
    .control_channel_enable(ctrl), .dual_link_active(dual),
    .primary_input_enable(pri), .secondary_input_enable(sec),
    .local_general_pin_zero(pin), .filtered_backchannel(filt),
    .secondary_backchannel(bch), .equalizer_minimum_setting(min_set),
    .equalizer_adaptation_restart(rst_eq),
    .equalizer_floor_active(fl_act), .equalizer_floor_port0(fl0),
    .equalizer_floor_port1(fl1));

  // ============================================================
  // comparison, reporting and end of run
  task automatic check(input string n, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask : rd

  // ============================================================
  // read data monitor: answer stands from the edge after the read
  always @(posedge clk) rd_q <= reg_rd;
  always @(negedge clk) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("Error reg_rdata expected none seen %h", reg_rdata);
      end else
        check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    $display("Error watchdog expected done seen running");
    summarize();
  end

  // ============================================================
  // main sequence
  logic [7:0] adr[4] = '{8'h2b, 8'h2e, 8'h34, 8'h35};
  logic [7:0] msk[4] = '{8'h03, 8'h80, 8'h7b, 8'h70};
  initial begin
    void'($urandom(60));
    min_set = 8'($urandom);
    repeat (6) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) rd(adr[i], i == 2 ? 8'h01 : 8'h00);
    rd(8'h40, 8'h00);
    check("primary_input_enable", pri, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(adr[i], 8'hff);
      rd(adr[i], msk[i]);
    end
    check("audio_strobe_rising", strobe, 1'b1);
    check("pixel_clock_from_self_test", pixclk, 1'b1);
    check("equalizer_floor_active", fl_act, 2'b11);
    check("equalizer_floor_port1", fl1, min_set);
    check("equalizer_floor_port0", fl0, min_set);
    // restart bit goes low in both copies: one pulse only
    wr(8'h35, 8'h10);
    check("equalizer_adaptation_restart", rst_eq, 1'b1);
    check("equalizer_floor_active", fl_act, 2'b00);
    tick(1);
    check("equalizer_adaptation_restart", rst_eq, 1'b0);
    wr(8'h2b, 8'h00);
    wr(8'h2e, 8'h00);
    tick(2);
    check("audio_strobe_rising", strobe, 1'b0);
    check("pixel_clock_from_self_test", pixclk, 1'b0);
    wr(8'h34, 8'h02);
    wr(8'h35, 8'h30);
    rd(8'h35, 8'h30);
    check("equalizer_floor_active", fl_act, 2'b10);
    check("equalizer_floor_port0", fl0, 8'h00);
    wr(8'h34, 8'h01);
    // first port only: port-one copy must keep its value
    wr(8'h35, 8'h20);
    rd(8'h35, 8'h20);
    wr(8'h34, 8'h03);
    rd(8'h35, 8'h30);
    // audio fifo flags: set, accumulate, clear, status not writable
    ovr = 1'b1;
    tick(1);
    ovr = 1'b0;
    rd(8'h2b, 8'h08);
    udr = 1'b1;
    tick(1);
    udr = 1'b0;
    rd(8'h2b, 8'h0c);
    // overrun event in the clearing cycle wins over the clear
    ovr = 1'b1;
    wr(8'h2b, 8'h02);
    ovr = 1'b0;
    rd(8'h2b, 8'h0a);
    wr(8'h2b, 8'h02);
    rd(8'h2b, 8'h02);
    wr(8'h2b, 8'h0c);
    rd(8'h2b, 8'h00);
    // lock indication in both modes
    link = 1'b1;
    voff = 1'b1;
    wr(8'h34, 8'h01);
    tick(2);
    check("receive_lock", lock, 1'b0);
    check("video_generate", vgen, 1'b0);
    check("control_channel_enable", ctrl, 1'b1);
    voff = 1'b0;
    tick(2);
    check("receive_lock", lock, 1'b1);
    check("video_generate", vgen, 1'b1);
    voff = 1'b1;
    wr(8'h34, 8'h41);
    tick(2);
    check("receive_lock", lock, 1'b1);
    link = 1'b0;
    tick(2);
    check("receive_lock", lock, 1'b0);
    check("control_channel_enable", ctrl, 1'b0);
    // every input mode, with a random auto-detect result
    for (int m = 0; m < 4; m++) begin
      det = 1'($urandom);
      wr(8'h34, {3'h0, 2'(m), 3'h1});
      tick(2);
      check("dual_link_active", dual, m == 1 || (m == 0 && det));
      check("primary_input_enable", pri, m != 3);
      check("secondary_input_enable", sec,
            m == 1 || m == 3 || (m == 0 && det));
    end
    // raw back channel passes the pin; normal mode takes filtered bit
    wr(8'h34, 8'h21);
    for (int i = 0; i < 4; i++) begin
      pin = 1'($urandom);
      filt = ~pin;
      tick(4);
      check("secondary_backchannel", bch, pin);
    end
    wr(8'h34, 8'h01);
    tick(2);
    check("secondary_backchannel", bch, filt);
    for (int i = 0; i < 10 && exp_q.size() != 0; i++) tick(1);
    if (exp_q.size() != 0) begin
      fails++;
      $display("Error read_queue expected empty seen pending");
    end
    summarize();
  end
endmodule : tb_deser_link_audio_ctrl_regs
